//--- rtl/bslse_exec.sv
`timescale 1ns/1ps
module bslse_exec (
    input wire logic clk,
    input wire logic rstn,
    input wire logic issue,
    input wire bslse_pkg::bslse_instr_s instr,
    input wire logic [7:0] status_flags,
    input wire bslse_pkg::bslse_ptr_wr_s ptr_wr,
    input wire logic [7:0] mem_rdata,
    output logic ready,
    output logic done,
    output logic [15:0] pc_out,
    output logic mem_req,
    output logic mem_we,
    output logic [15:0] mem_addr,
    output logic [7:0] mem_wdata,
    output logic load_we,
    output logic [4:0] load_dst,
    output logic [7:0] load_data,
    output logic [2:0][15:0] ptrs
);

    // ****************************************
    // Decode helpers
    // ****************************************
    function automatic logic branch_cond(input bslse_pkg::bslse_op_e op, input logic [2:0] s,
                                         input logic [7:0] f);
        case (op)
            bslse_pkg::OP_BRANCH_FLAG_ONE: branch_cond = f[s];
            bslse_pkg::OP_BRANCH_FLAG_ZERO: branch_cond = !f[s];
            bslse_pkg::OP_BRANCH_EQUAL: branch_cond = f[bslse_pkg::FLAG_Z];
            bslse_pkg::OP_BRANCH_NOT_EQUAL: branch_cond = !f[bslse_pkg::FLAG_Z];
            bslse_pkg::OP_BRANCH_CARRY_ONE,
            bslse_pkg::OP_BRANCH_LOWER: branch_cond = f[bslse_pkg::FLAG_C];
            bslse_pkg::OP_BRANCH_CARRY_ZERO,
            bslse_pkg::OP_BRANCH_SAME_OR_HIGHER: branch_cond = !f[bslse_pkg::FLAG_C];
            bslse_pkg::OP_BRANCH_MINUS: branch_cond = f[bslse_pkg::FLAG_N];
            bslse_pkg::OP_BRANCH_PLUS: branch_cond = !f[bslse_pkg::FLAG_N];
            bslse_pkg::OP_BRANCH_SIGNED_GE:
                branch_cond = !(f[bslse_pkg::FLAG_N] ^ f[bslse_pkg::FLAG_V]);
            bslse_pkg::OP_BRANCH_SIGNED_LT:
                branch_cond = f[bslse_pkg::FLAG_N] ^ f[bslse_pkg::FLAG_V];
            bslse_pkg::OP_BRANCH_HALF_CARRY_ONE: branch_cond = f[bslse_pkg::FLAG_H];
            bslse_pkg::OP_BRANCH_HALF_CARRY_ZERO: branch_cond = !f[bslse_pkg::FLAG_H];
            bslse_pkg::OP_BRANCH_TRANSFER_BIT_ONE: branch_cond = f[bslse_pkg::FLAG_T];
            bslse_pkg::OP_BRANCH_TRANSFER_BIT_ZERO: branch_cond = !f[bslse_pkg::FLAG_T];
            bslse_pkg::OP_BRANCH_OVERFLOW_ONE: branch_cond = f[bslse_pkg::FLAG_V];
            bslse_pkg::OP_BRANCH_OVERFLOW_ZERO: branch_cond = !f[bslse_pkg::FLAG_V];
            bslse_pkg::OP_BRANCH_IRQ_ENABLED: branch_cond = f[bslse_pkg::FLAG_I];
            bslse_pkg::OP_BRANCH_IRQ_DISABLED: branch_cond = !f[bslse_pkg::FLAG_I];
            default: branch_cond = 1'b0;
        endcase
    endfunction

    function automatic logic [1:0] ptr_index(input logic [1:0] sel, input logic offset_form);
        if (sel == bslse_pkg::PTR_X) begin
            ptr_index = offset_form ? bslse_pkg::PTR_Y : bslse_pkg::PTR_X;
        end else if (sel == bslse_pkg::PTR_Y) begin
            ptr_index = bslse_pkg::PTR_Y;
        end else begin
            ptr_index = bslse_pkg::PTR_Z;
        end
    endfunction

    // ****************************************
    // State
    // ****************************************
    bslse_pkg::bslse_state_e state_reg, state_next;
    logic [1:0] cnt_reg, cnt_next;
    logic ready_reg, ready_next;
    logic done_reg, done_next;
    logic [15:0] pc_reg, pc_next;
    logic mem_req_reg, mem_req_next;
    logic mem_we_reg, mem_we_next;
    logic [15:0] mem_addr_reg, mem_addr_next;
    logic [7:0] mem_wdata_reg, mem_wdata_next;
    logic load_we_reg, load_we_next;
    logic [4:0] load_dst_reg, load_dst_next;
    logic [7:0] load_data_reg, load_data_next;
    logic [2:0][15:0] ptr_reg, ptr_next;

    logic accept;
    logic is_branch;
    logic is_skip;
    logic is_mem;
    logic is_offset;
    logic taken;
    logic skip_hit;
    logic [1:0] sel_idx;
    logic [15:0] sel_ptr;
    logic [15:0] br_tgt;
    logic [15:0] skip_tgt;
    logic [15:0] seq_pc;

    // ****************************************
    // Next-state logic
    // ****************************************
    always_comb begin
        accept = issue && ready_reg && (state_reg == bslse_pkg::ST_IDLE);
        is_branch = (instr.op >= bslse_pkg::OP_BRANCH_FLAG_ONE) && (instr.op <= bslse_pkg::OP_BRANCH_IRQ_DISABLED);
        is_skip = (instr.op >= bslse_pkg::OP_SKIP_IF_REG_BIT_ONE) && (instr.op <= bslse_pkg::OP_SKIP_IF_IO_BIT_ONE);
        is_mem = (instr.op >= bslse_pkg::OP_POINTER_LOAD) && (instr.op <= bslse_pkg::OP_OFFSET_STORE);
        is_offset = (instr.op == bslse_pkg::OP_OFFSET_LOAD) || (instr.op == bslse_pkg::OP_OFFSET_STORE);
        taken = branch_cond(instr.op, instr.flag_idx, status_flags);
        skip_hit = (instr.op == bslse_pkg::OP_SKIP_IF_IO_BIT_ZERO) ? !instr.test_byte[instr.bit_idx]
                                                                  : instr.test_byte[instr.bit_idx];
        sel_idx = ptr_index(instr.ptr_sel, is_offset);
        sel_ptr = ptr_reg[sel_idx];
        seq_pc = instr.pc + 16'h0001;
        br_tgt = instr.pc + {{9{instr.k_rel[6]}}, instr.k_rel} + 16'h0001;
        skip_tgt = instr.pc + (instr.next_two_words ? 16'h0003 : 16'h0002);

        state_next = state_reg;
        cnt_next = cnt_reg;
        ready_next = 1'b1;
        done_next = 1'b0;
        pc_next = pc_reg;
        mem_req_next = 1'b0;
        mem_we_next = mem_we_reg;
        mem_addr_next = mem_addr_reg;
        mem_wdata_next = mem_wdata_reg;
        load_we_next = 1'b0;
        load_dst_next = load_dst_reg;
        load_data_next = load_data_reg;
        ptr_next = ptr_reg;
        if (ptr_wr.en) begin
            ptr_next[ptr_index(ptr_wr.sel, 1'b0)] = ptr_wr.data;
        end

        unique case (state_reg)
            bslse_pkg::ST_IDLE: begin
                if (accept) begin
                    pc_next = seq_pc;
                    cnt_next = bslse_pkg::CYC_BASE;
                    if (is_branch && taken) begin
                        pc_next = br_tgt;
                        cnt_next = bslse_pkg::CYC_BRANCH_TAKEN;
                    end else if (is_skip && skip_hit) begin
                        pc_next = skip_tgt;
                        cnt_next = instr.next_two_words ? bslse_pkg::CYC_SKIP_TWO_WORD
                                                        : bslse_pkg::CYC_SKIP_ONE_WORD;
                    end
                    if (is_mem) begin
                        state_next = bslse_pkg::ST_MEM;
                        ready_next = 1'b0;
                        mem_req_next = 1'b1;
                        mem_we_next = (instr.op == bslse_pkg::OP_POINTER_STORE) ||
                                      (instr.op == bslse_pkg::OP_OFFSET_STORE);
                        mem_wdata_next = instr.src_data;
                        load_dst_next = instr.dst_idx;
                        if (instr.op == bslse_pkg::OP_ABSOLUTE_LOAD) begin
                            mem_addr_next = instr.abs_addr;
                        end else if (is_offset) begin
                            mem_addr_next = sel_ptr + {10'h000, instr.q_disp};
                        end else if (instr.ptr_mode == bslse_pkg::MODE_PRE_DEC) begin
                            mem_addr_next = sel_ptr - 16'h0001;
                            ptr_next[sel_idx] = sel_ptr - 16'h0001;
                        end else begin
                            mem_addr_next = sel_ptr;
                            if (instr.ptr_mode == bslse_pkg::MODE_POST_INC) begin
                                ptr_next[sel_idx] = sel_ptr + 16'h0001;
                            end
                        end
                    end else if (cnt_next == bslse_pkg::CYC_BASE) begin
                        done_next = 1'b1;
                    end else begin
                        state_next = bslse_pkg::ST_WAIT;
                        ready_next = 1'b0;
                        cnt_next = cnt_next - 2'h1;
                    end
                end
            end
            bslse_pkg::ST_WAIT: begin
                if (cnt_reg == bslse_pkg::CYC_BASE) begin
                    state_next = bslse_pkg::ST_IDLE;
                    done_next = 1'b1;
                end else begin
                    ready_next = 1'b0;
                    cnt_next = cnt_reg - 2'h1;
                end
            end
            bslse_pkg::ST_MEM: begin
                state_next = bslse_pkg::ST_IDLE;
                done_next = 1'b1;
                if (!mem_we_reg) begin
                    load_we_next = 1'b1;
                    load_data_next = mem_rdata;
                end
            end
            default: begin
                state_next = bslse_pkg::ST_IDLE;
            end
        endcase
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge clk) begin
        if (!rstn) begin
            state_reg <= bslse_pkg::ST_IDLE;
            cnt_reg <= bslse_pkg::CYC_BASE;
            ready_reg <= 1'b0;
            done_reg <= 1'b0;
            pc_reg <= bslse_pkg::PC_RESET;
            mem_req_reg <= 1'b0;
            mem_we_reg <= 1'b0;
            mem_addr_reg <= bslse_pkg::PTR_RESET;
            mem_wdata_reg <= bslse_pkg::BYTE_RESET;
            load_we_reg <= 1'b0;
            load_dst_reg <= 5'h00;
            load_data_reg <= bslse_pkg::BYTE_RESET;
            ptr_reg <= {3{bslse_pkg::PTR_RESET}};
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            ready_reg <= ready_next;
            done_reg <= done_next;
            pc_reg <= pc_next;
            mem_req_reg <= mem_req_next;
            mem_we_reg <= mem_we_next;
            mem_addr_reg <= mem_addr_next;
            mem_wdata_reg <= mem_wdata_next;
            load_we_reg <= load_we_next;
            load_dst_reg <= load_dst_next;
            load_data_reg <= load_data_next;
            ptr_reg <= ptr_next;
        end
    end

    assign ready = ready_reg;
    assign done = done_reg;
    assign pc_out = pc_reg;
    assign mem_req = mem_req_reg;
    assign mem_we = mem_we_reg;
    assign mem_addr = mem_addr_reg;
    assign mem_wdata = mem_wdata_reg;
    assign load_we = load_we_reg;
    assign load_dst = load_dst_reg;
    assign load_data = load_data_reg;
    assign ptrs = ptr_reg;

    // ****************************************
    // Checks
    // ****************************************
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);

    sequence one_cycle_done;
        done && ready;
    endsequence
    sequence two_cycle_done;
        !done ##1 (done && ready);
    endsequence
    sequence three_cycle_done;
        !done ##1 !done ##1 (done && ready);
    endsequence
    sequence mem_two_cycle(logic [15:0] a, logic w);
        (mem_req && !ready && mem_addr == a && mem_we == w) ##1 (done && !mem_req);
    endsequence

    reg_skip_a: assert property (accept && instr.op == bslse_pkg::OP_SKIP_IF_REG_BIT_ONE
        && instr.test_byte[instr.bit_idx] && instr.next_two_words
        |=> pc_out == $past(instr.pc) + 16'h0003 ##0 three_cycle_done)
        else $error("register bit skip wrong");
    io_skip_zero_a: assert property (accept && instr.op == bslse_pkg::OP_SKIP_IF_IO_BIT_ZERO
        |=> (pc_out == ($past(instr.test_byte[instr.bit_idx]) ? $past(instr.pc) + 16'h0001
            : $past(instr.pc) + ($past(instr.next_two_words) ? 16'h0003 : 16'h0002))))
        else $error("io bit zero skip wrong");
    io_skip_one_a: assert property (accept && instr.op == bslse_pkg::OP_SKIP_IF_IO_BIT_ONE
        && instr.test_byte[instr.bit_idx] && !instr.next_two_words
        |=> pc_out == $past(instr.pc) + 16'h0002 ##0 two_cycle_done)
        else $error("io bit one skip wrong");
    branch_taken_a: assert property (accept && is_branch && taken
        |=> pc_out == $past(instr.pc) + {{9{$past(instr.k_rel[6])}}, $past(instr.k_rel)} + 16'h0001
            ##0 two_cycle_done)
        else $error("taken branch wrong");
    branch_equal_a: assert property (accept && instr.op == bslse_pkg::OP_BRANCH_EQUAL
        && !status_flags[bslse_pkg::FLAG_Z] |=> pc_out == $past(instr.pc) + 16'h0001 ##0 one_cycle_done)
        else $error("equal branch taken on nonzero");
    branch_carry_a: assert property (accept && instr.op == bslse_pkg::OP_BRANCH_SAME_OR_HIGHER
        && !status_flags[bslse_pkg::FLAG_C] |=> two_cycle_done)
        else $error("same or higher not taken");
    branch_minus_a: assert property (accept && instr.op == bslse_pkg::OP_BRANCH_MINUS
        && !status_flags[bslse_pkg::FLAG_N] |=> one_cycle_done)
        else $error("minus branch timing wrong");
    branch_signed_a: assert property (accept && instr.op == bslse_pkg::OP_BRANCH_SIGNED_LT
        && (status_flags[bslse_pkg::FLAG_N] ^ status_flags[bslse_pkg::FLAG_V]) |=> two_cycle_done)
        else $error("signed less branch not taken");
    branch_half_a: assert property (accept && instr.op == bslse_pkg::OP_BRANCH_HALF_CARRY_ZERO
        && status_flags[bslse_pkg::FLAG_H] |=> one_cycle_done)
        else $error("half carry branch wrong");
    branch_transfer_a: assert property (accept && instr.op == bslse_pkg::OP_BRANCH_TRANSFER_BIT_ONE
        && status_flags[bslse_pkg::FLAG_T] |=> two_cycle_done)
        else $error("transfer branch wrong");
    branch_overflow_a: assert property (accept && instr.op == bslse_pkg::OP_BRANCH_OVERFLOW_ZERO
        && !status_flags[bslse_pkg::FLAG_V] |=> two_cycle_done)
        else $error("overflow branch wrong");
    branch_irq_a: assert property (accept && instr.op == bslse_pkg::OP_BRANCH_IRQ_DISABLED
        && status_flags[bslse_pkg::FLAG_I] |=> one_cycle_done)
        else $error("irq branch wrong");
    load_post_a: assert property (accept && instr.op == bslse_pkg::OP_POINTER_LOAD
        && instr.ptr_mode == bslse_pkg::MODE_POST_INC && !ptr_wr.en
        |=> mem_two_cycle($past(sel_ptr), 1'b0) ##0 load_we)
        else $error("post increment load wrong");
    load_pre_a: assert property (accept && instr.op == bslse_pkg::OP_POINTER_LOAD
        && instr.ptr_mode == bslse_pkg::MODE_PRE_DEC && !ptr_wr.en
        |=> ptrs[$past(sel_idx)] == $past(sel_ptr) - 16'h0001 ##0 mem_two_cycle($past(sel_ptr) - 16'h0001, 1'b0))
        else $error("pre decrement load wrong");
    load_offset_a: assert property (accept && instr.op == bslse_pkg::OP_OFFSET_LOAD && !ptr_wr.en
        |=> ptrs[$past(sel_idx)] == $past(sel_ptr) ##0 $past(sel_idx) != bslse_pkg::PTR_X)
        else $error("offset load moved pointer");
    load_abs_a: assert property (accept && instr.op == bslse_pkg::OP_ABSOLUTE_LOAD
        |=> mem_two_cycle($past(instr.abs_addr), 1'b0) ##0 load_we)
        else $error("absolute load wrong");
    store_post_a: assert property (accept && instr.op == bslse_pkg::OP_POINTER_STORE
        && instr.ptr_mode == bslse_pkg::MODE_POST_INC && !ptr_wr.en
        |=> ptrs[$past(sel_idx)] == $past(sel_ptr) + 16'h0001 ##0 mem_two_cycle($past(sel_ptr), 1'b1))
        else $error("post increment store wrong");
    store_pre_a: assert property (accept && instr.op == bslse_pkg::OP_POINTER_STORE
        && instr.ptr_mode == bslse_pkg::MODE_PRE_DEC
        |=> mem_two_cycle($past(sel_ptr) - 16'h0001, 1'b1) ##0 !load_we)
        else $error("pre decrement store wrong");
    store_offset_a: assert property (accept && instr.op == bslse_pkg::OP_OFFSET_STORE
        |=> mem_wdata == $past(instr.src_data) ##0 mem_two_cycle($past(sel_ptr) + {10'h000, $past(instr.q_disp)}, 1'b1))
        else $error("offset store wrong");
    offset_unsigned_a: assert property (accept && is_offset && instr.q_disp[5]
        |=> mem_addr == $past(sel_ptr) + {10'h000, $past(instr.q_disp)})
        else $error("displacement not unsigned");

endmodule

//--- rtl/bslse_pkg.sv
package bslse_pkg;

    // ****************************************
    // Status flag positions
    // ****************************************
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_S = 4;
    localparam int FLAG_H = 5;
    localparam int FLAG_T = 6;
    localparam int FLAG_I = 7;

    // ****************************************
    // Pointer selects and addressing modes
    // ****************************************
    localparam logic [1:0] PTR_X = 2'h0;
    localparam logic [1:0] PTR_Y = 2'h1;
    localparam logic [1:0] PTR_Z = 2'h2;
    localparam logic [1:0] MODE_PLAIN = 2'h0;
    localparam logic [1:0] MODE_POST_INC = 2'h1;
    localparam logic [1:0] MODE_PRE_DEC = 2'h2;

    // ****************************************
    // Cycle counts and reset values
    // ****************************************
    localparam logic [1:0] CYC_BASE = 2'h1;
    localparam logic [1:0] CYC_BRANCH_TAKEN = 2'h2;
    localparam logic [1:0] CYC_SKIP_ONE_WORD = 2'h2;
    localparam logic [1:0] CYC_SKIP_TWO_WORD = 2'h3;
    localparam logic [15:0] PTR_RESET = 16'h0000;
    localparam logic [15:0] PC_RESET = 16'h0000;
    localparam logic [7:0] BYTE_RESET = 8'h00;

    typedef enum logic [4:0] {
        OP_NOP                     = 5'h00,
        OP_SKIP_IF_REG_BIT_ONE     = 5'h01,
        OP_SKIP_IF_IO_BIT_ZERO     = 5'h02,
        OP_SKIP_IF_IO_BIT_ONE      = 5'h03,
        OP_BRANCH_FLAG_ONE         = 5'h04,
        OP_BRANCH_FLAG_ZERO        = 5'h05,
        OP_BRANCH_EQUAL            = 5'h06,
        OP_BRANCH_NOT_EQUAL        = 5'h07,
        OP_BRANCH_CARRY_ONE        = 5'h08,
        OP_BRANCH_CARRY_ZERO       = 5'h09,
        OP_BRANCH_SAME_OR_HIGHER   = 5'h0A,
        OP_BRANCH_LOWER            = 5'h0B,
        OP_BRANCH_MINUS            = 5'h0C,
        OP_BRANCH_PLUS             = 5'h0D,
        OP_BRANCH_SIGNED_GE        = 5'h0E,
        OP_BRANCH_SIGNED_LT        = 5'h0F,
        OP_BRANCH_HALF_CARRY_ONE   = 5'h10,
        OP_BRANCH_HALF_CARRY_ZERO  = 5'h11,
        OP_BRANCH_TRANSFER_BIT_ONE = 5'h12,
        OP_BRANCH_TRANSFER_BIT_ZERO = 5'h13,
        OP_BRANCH_OVERFLOW_ONE     = 5'h14,
        OP_BRANCH_OVERFLOW_ZERO    = 5'h15,
        OP_BRANCH_IRQ_ENABLED      = 5'h16,
        OP_BRANCH_IRQ_DISABLED     = 5'h17,
        OP_POINTER_LOAD            = 5'h18,
        OP_OFFSET_LOAD             = 5'h19,
        OP_ABSOLUTE_LOAD           = 5'h1A,
        OP_POINTER_STORE           = 5'h1B,
        OP_OFFSET_STORE            = 5'h1C
    } bslse_op_e;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_WAIT = 2'h1,
        ST_MEM  = 2'h2
    } bslse_state_e;

    typedef struct packed {
        bslse_op_e op;
        logic [1:0] ptr_sel;
        logic [1:0] ptr_mode;
        logic [2:0] bit_idx;
        logic [2:0] flag_idx;
        logic [6:0] k_rel;
        logic [5:0] q_disp;
        logic [15:0] abs_addr;
        logic [15:0] pc;
        logic [7:0] test_byte;
        logic [7:0] src_data;
        logic [4:0] dst_idx;
        logic next_two_words;
    } bslse_instr_s;

    typedef struct packed {
        logic en;
        logic [1:0] sel;
        logic [15:0] data;
    } bslse_ptr_wr_s;

endpackage

//--- test/branch_skip_load_store_exec_tb.sv
`timescale 1ns/1ps
module branch_skip_load_store_exec_tb;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic issue = 1'b0;
    bslse_pkg::bslse_instr_s instr = '0;
    logic [7:0] status_flags = 8'h00;
    bslse_pkg::bslse_ptr_wr_s ptr_wr = '0;
    logic ready, done, mem_req, mem_we, load_we, mwe, t;
    logic [15:0] pc_out, mem_addr, ma, c;
    logic [7:0] mem_rdata, mem_wdata, load_data, mwd, f;
    logic [4:0] load_dst;
    logic [2:0][15:0] ptrs;
    logic [2:0] bi;
    int err_count = 0;
    int num_checks = 0;
    int cyc = 0;
    int fi [24] = '{0, 0, 0, 0, 4, 5, 1, 1, 0, 0, 0, 0, 2, 2, 0, 0, 5, 5, 6, 6, 3, 3, 7, 7};
    logic [23:0] pol = 24'h559950;
    bslse_exec DUT (.clk(clk), .rstn(rstn), .issue(issue), .instr(instr), .status_flags(status_flags),
        .ptr_wr(ptr_wr), .mem_rdata(mem_rdata), .ready(ready), .done(done), .pc_out(pc_out), .mem_req(mem_req),
        .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .load_we(load_we), .load_dst(load_dst),
        .load_data(load_data), .ptrs(ptrs));
    bslse_mem mem_model (.clk(clk), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
    always #5 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (mem_req === 1'b1) begin
            ma <= mem_addr;
            mwe <= mem_we;
            mwd <= mem_wdata;
        end
        if (cyc == 3000) begin
            err_count++;
            stop_test();
        end
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic run();
        c = 16'h0000;
        issue <= 1'b1;
        @(posedge clk);
        issue <= 1'b0;
        do begin
            @(posedge clk);
            c++;
        end while (done !== 1'b1 && c < 16'h0008);
    endtask
    task automatic mop(input logic [4:0] o, input logic [1:0] s, m, input logic [5:0] q,
                       input logic [15:0] a, p, input logic [7:0] d);
        instr.op <= bslse_pkg::bslse_op_e'(o);
        instr.ptr_sel <= s;
        instr.ptr_mode <= m;
        instr.q_disp <= q;
        instr.abs_addr <= a;
        instr.src_data <= d;
        instr.dst_idx <= o;
        run();
        chk(16'(load_we), 16'(o < 5'h1B));
        chk(16'(load_dst), 16'(o));
        chk(c, 16'h0002);
        chk(ma, a);
        chk(16'(mwe), 16'(o > 5'h1A));
        chk(16'(o > 5'h1A ? mwd : load_data), 16'(d));
        chk(ptrs[s], p);
    endtask
    // ****
    // Skips, branches, then loads and stores
    // ****
    initial begin
        instr.pc <= 16'h0100;
        instr.k_rel <= 7'h7E;
        repeat (20) @(posedge clk);
        chk(ptrs[0], 16'h0000);
        rstn <= 1'b1;
        repeat (2) @(posedge clk);
        for (int o = 1; o < 4; o++) begin
            for (int w = 0; w < 4; w++) begin
                bi = 3'(o + w * 2);
                instr.op <= bslse_pkg::bslse_op_e'(o);
                instr.next_two_words <= w[1];
                instr.bit_idx <= bi;
                instr.test_byte <= (8'h01 << bi) ^ {8{w[0]}};
                t = (o == 2) == w[0];
                run();
                chk(c, t ? 16'h0002 + w[1] : 16'h0001);
                chk(pc_out, t ? 16'h0102 + w[1] : 16'h0101);
            end
        end
        $display("skip tests finished");
        for (int o = 4; o < 24; o++) begin
            for (int j = 0; j < 3; j++) begin
                f = j == 0 ? 8'h00 : (j == 1 ? 8'hFF : 8'h5A);
                instr.op <= bslse_pkg::bslse_op_e'(o);
                instr.flag_idx <= 3'(o);
                status_flags <= f;
                t = (o == 14 || o == 15 ? f[2] ^ f[3] : f[fi[o]]) == pol[o];
                run();
                chk(c, t ? 16'h0002 : 16'h0001);
                chk(pc_out, t ? 16'h00FF : 16'h0101);
            end
        end
        $display("branch tests finished");
        for (int i = 0; i < 3; i++) begin
            ptr_wr <= '{1'b1, 2'(i), 16'(i * 16 + 16)};
            @(posedge clk);
        end
        ptr_wr <= '{1'b0, 2'h0, 16'h0000};
        mop(5'h18, 2'h0, 2'h0, 6'h00, 16'h0010, 16'h0010, 8'hB5);
        mop(5'h18, 2'h1, 2'h1, 6'h00, 16'h0020, 16'h0021, 8'h85);
        mop(5'h18, 2'h2, 2'h2, 6'h00, 16'h002F, 16'h002F, 8'h8A);
        mop(5'h19, 2'h2, 2'h0, 6'h3F, 16'h006E, 16'h002F, 8'hCB);
        mop(5'h1A, 2'h0, 2'h0, 6'h00, 16'h0080, 16'h0010, 8'h25);
        mop(5'h1B, 2'h0, 2'h1, 6'h00, 16'h0010, 16'h0011, 8'h3C);
        mop(5'h1B, 2'h1, 2'h2, 6'h00, 16'h0020, 16'h0020, 8'h5E);
        mop(5'h1C, 2'h1, 2'h0, 6'h05, 16'h0025, 16'h0020, 8'h77);
        mop(5'h19, 2'h1, 2'h0, 6'h05, 16'h0025, 16'h0020, 8'h77);
        mop(5'h18, 2'h0, 2'h2, 6'h00, 16'h0010, 16'h0010, 8'h3C);
        $display("load store tests finished");
        stop_test();
    end
endmodule

//--- test/bslse_mem.sv
`timescale 1ns/1ps
// ****
// Data memory with combinational read
// ****
module bslse_mem (
    input wire logic clk,
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [15:0] mem_addr,
    input wire logic [7:0] mem_wdata,
    output logic [7:0] mem_rdata
);
    logic [7:0] mem [256];
    logic [7:0] filler = 8'h00;
    initial for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'hA5;
    always @(posedge clk) begin
        filler <= ~filler;
        if (mem_req && mem_we) begin
            mem[mem_addr[7:0]] <= mem_wdata;
        end
    end
    // Changing pattern when no read is asked
    assign mem_rdata = (mem_req && !mem_we) ? mem[mem_addr[7:0]] : filler;
endmodule
